//--- rtl/adc_serial_link_timing.sv
/*
 device side sequencing of the converter serial link: reset recovery, light
 sleep and power down recovery, ready/strobe output and data output enable
 across the spi-compatible and source-synchronous modes.
 assumes pins arrive asynchronously and are synchronised here; the data bits
 to send come in parallel from converter logic on the same clock.
*/
`timescale 1ns/1ns
module adc_serial_link_timing #(
   parameter int unsigned DATA_W     = 16,
   parameter int unsigned READY_CYC  = adc_link_pkg::RESET_READY_CYC,
   parameter int unsigned PWRUP_CYC_P = adc_link_pkg::PWRUP_CYC
) (
   input  wire logic                       clk_i,            // system clock
   input  wire logic                       reset_i,          // synchronous reset
   input  wire adc_link_pkg::link_pins_t   pins_i,           // cs_n, sclk, reset_n pins
   input  wire adc_link_pkg::link_ctrl_t   ctrl_i,           // mode, divider, sleep, kind
   input  wire logic [DATA_W-1:0]          data_i,           // word to shift out
   output logic                            ready_strobe_output_o, // ready/strobe pin
   output logic                            sdo_o,            // serial data out
   output logic                            sdo_oe_o,         // data out enable
   output logic                            ready_o           // device operational
);
   import adc_link_pkg::*;

   typedef struct packed {
      link_pins_t   s1;
      link_pins_t   s2;
      logic         sclk_d;
      link_state_t  st;
      logic [CNT_W-1:0]  cnt;
      logic [DATA_W-1:0] shift;
      logic         ready_strobe_output;
      logic         sdo;
      logic         oe;
      logic         rdy;
      logic         nap_d;
      logic         pd_d;
      frame_kind_t  kind;
   } top_state_t;

   top_state_t s_reg;
   top_state_t s_next;
   logic       str_run;
   logic       str_tick;
   logic       str_level;

   function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
      return CNT_W'(n);
   endfunction

   strobe_gen u_strobe (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .run_i   (str_run),
      .div_i   (ctrl_i.div),
      .tick_o  (str_tick),
      .level_o (str_level)
   );

   always_comb begin
      s_next       = s_reg;
      s_next.s1    = pins_i;
      s_next.s2    = s_reg.s1;
      s_next.sclk_d = s_reg.s2.sclk;
      s_next.nap_d = ctrl_i.nap;
      str_run      = 1'b0;
      if (s_reg.st == ST_FRAME && ctrl_i.mode == MODE_SRC_INT
          && s_reg.cnt >= cyc(STR_START_CYC)) begin
         str_run = 1'b1;
      end
      case (s_reg.st)
         ST_RESET: begin
            s_next.ready_strobe_output = 1'b0;
            s_next.rdy = 1'b0;
            s_next.oe  = 1'b0;
            if (!s_reg.s2.reset_n) begin
               if (s_reg.cnt < cyc(RESET_LOW_CYC)) begin
                  s_next.cnt = s_reg.cnt + 1'b1;
               end
            end else if (s_reg.cnt >= cyc(RESET_LOW_CYC)) begin
               s_next.st  = ST_BOOT;
               s_next.cnt = '0;
            end else begin
               s_next.st  = ST_IDLE;
               s_next.ready_strobe_output = 1'b1;
               s_next.rdy = 1'b1;
            end
         end
         ST_BOOT: begin
            s_next.cnt = s_reg.cnt + 1'b1;
            if (s_reg.cnt >= cyc(READY_CYC - 1)) begin
               s_next.st  = ST_IDLE;
               s_next.ready_strobe_output = 1'b1;
               s_next.rdy = 1'b1;
            end
         end
         ST_IDLE: begin
            s_next.cnt  = '0;
            s_next.pd_d = ctrl_i.power_down;
            if (ctrl_i.power_down || ctrl_i.nap) begin
               s_next.st  = ST_NAP;
               s_next.rdy = 1'b0;
            end else if (!s_reg.s2.cs_n) begin
               s_next.st    = ST_FRAME;
               s_next.kind  = ctrl_i.kind;
               s_next.shift = data_i;
               s_next.oe    = 1'b1;
               s_next.sdo   = data_i[DATA_W-1];
               if (ctrl_i.mode == MODE_SPI) begin
                  s_next.ready_strobe_output = 1'b0;
               end else begin
                  s_next.ready_strobe_output = 1'b0;
               end
            end
         end
         ST_FRAME: begin
            if (s_reg.cnt < cyc(STR_START_CYC)) begin
               s_next.cnt = s_reg.cnt + 1'b1;
            end
            if (s_reg.s2.cs_n) begin
               s_next.oe  = 1'b0;
               s_next.cnt = '0;
               if (s_reg.kind == FRAME_RW) begin
                  s_next.st  = ST_TAIL;
                  s_next.ready_strobe_output = 1'b0;
               end else begin
                  s_next.st  = ST_IDLE;
                  s_next.ready_strobe_output = 1'b1;
               end
            end else if (ctrl_i.mode == MODE_SRC_EXT
                         && s_reg.s2.sclk && !s_reg.sclk_d) begin
               s_next.ready_strobe_output   = ~s_reg.ready_strobe_output;
               s_next.shift = {s_reg.shift[DATA_W-2:0], 1'b0};
               s_next.sdo   = s_reg.shift[DATA_W-2];
            end else if (ctrl_i.mode == MODE_SRC_INT) begin
               // next level, so the strobe edge lands with the data change
               s_next.ready_strobe_output = str_level ^ str_tick;
               if (str_tick) begin
                  s_next.shift = {s_reg.shift[DATA_W-2:0], 1'b0};
                  s_next.sdo   = s_reg.shift[DATA_W-2];
               end
            end else if (ctrl_i.mode == MODE_SPI
                         && !s_reg.s2.sclk && s_reg.sclk_d) begin
               s_next.shift = {s_reg.shift[DATA_W-2:0], 1'b0};
               s_next.sdo   = s_reg.shift[DATA_W-2];
            end
         end
         ST_TAIL: begin
            s_next.cnt = s_reg.cnt + 1'b1;
            if (s_reg.cnt >= cyc(RW_READY_CYC - 1)) begin
               s_next.st  = ST_IDLE;
               s_next.ready_strobe_output = 1'b1;
               s_next.cnt = '0;
            end
         end
         ST_NAP: begin
            s_next.ready_strobe_output = 1'b0;
            s_next.cnt = '0;
            // power down seen during sleep stays latched through the wake
            if (ctrl_i.power_down) begin
               s_next.pd_d = 1'b1;
            end
            if (!ctrl_i.nap && !ctrl_i.power_down) begin
               s_next.st = ST_WAKE;
            end
         end
         ST_WAKE: begin
            s_next.cnt = s_reg.cnt + 1'b1;
            if ((!s_reg.pd_d && s_reg.cnt >= cyc(NAP_WAKE_CYC - 1))
                || (s_reg.cnt >= cyc(PWRUP_CYC_P - 1))) begin
               s_next.st  = ST_IDLE;
               s_next.ready_strobe_output = 1'b1;
               s_next.rdy = 1'b1;
               s_next.cnt = '0;
            end
         end
         default: begin
            s_next.st = ST_RESET;
         end
      endcase
      if (!s_reg.s2.reset_n && s_reg.st != ST_RESET) begin
         s_next.st  = ST_RESET;
         s_next.cnt = cyc(1);
         s_next.oe  = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         s_reg      <= '0;
         s_reg.s1   <= 3'b101;
         s_reg.s2   <= 3'b101;
         s_reg.st   <= ST_BOOT;
      end else begin
         s_reg <= s_next;
      end
   end

   assign ready_strobe_output_o = s_reg.ready_strobe_output;
   assign sdo_o                 = s_reg.sdo;
   assign sdo_oe_o              = s_reg.oe;
   assign ready_o               = s_reg.rdy;
endmodule

//--- rtl/adc_link_pkg.sv
/*
 package for the converter serial link timing block: modes, states, timing
 constants and the carrier structs shared by the top module and the strobe
 generator. assumes a 50 MHz system clock.
*/
package adc_link_pkg;

   localparam int unsigned CLK_PERIOD_NS = 20;

   // times as printed, in their own unit
   localparam int unsigned RESET_LOW_MIN_NS  = 100;
   localparam int unsigned RESET_READY_MAX_US = 1250;
   localparam int unsigned NAP_WAKE_MAX_NS   = 300;
   localparam int unsigned PWRUP_MAX_US      = 250;
   localparam int unsigned NOP_READY_MAX_NS  = 10;
   localparam int unsigned RW_READY_TYP_NS   = 70;
   localparam int unsigned RW_READY_MAX_NS   = 115;
   localparam int unsigned STR_START_MIN_NS  = 12;
   localparam int unsigned STR_START_MAX_NS  = 40;

   function automatic int unsigned ns_floor(input int unsigned ns);
      int unsigned c;
      c = ns / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   function automatic int unsigned ns_ceil(input int unsigned ns);
      int unsigned c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int unsigned RESET_LOW_CYC   = ns_ceil(RESET_LOW_MIN_NS);
   localparam int unsigned RESET_READY_CYC = ns_floor(RESET_READY_MAX_US * 1000);
   localparam int unsigned NAP_WAKE_CYC    = ns_floor(NAP_WAKE_MAX_NS);
   localparam int unsigned PWRUP_CYC       = ns_floor(PWRUP_MAX_US * 1000);
   localparam int unsigned RW_READY_CYC    = ns_floor(RW_READY_TYP_NS);
   localparam int unsigned STR_START_CYC   = ns_ceil(STR_START_MIN_NS);

   localparam int unsigned CNT_W = 17;

   typedef enum logic [1:0] {
      MODE_SPI,
      MODE_SRC_EXT,
      MODE_SRC_INT
   } link_mode_t;

   typedef enum logic [1:0] {
      DIV_1,
      DIV_2,
      DIV_4
   } strobe_div_t;

   typedef enum logic [1:0] {
      FRAME_NOP,
      FRAME_RW,
      FRAME_DATA
   } frame_kind_t;

   typedef enum logic [2:0] {
      ST_RESET,
      ST_BOOT,
      ST_IDLE,
      ST_FRAME,
      ST_TAIL,
      ST_NAP,
      ST_WAKE
   } link_state_t;

   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic reset_n;
   } link_pins_t;

   typedef struct packed {
      logic       nap;
      logic       power_down;
      link_mode_t mode;
      strobe_div_t div;
      frame_kind_t kind;
   } link_ctrl_t;

   localparam logic [1:0] DIV2_HALF = 2'h1;
   localparam logic [1:0] DIV4_HALF = 2'h3;

endpackage

//--- rtl/strobe_gen.sv
/*
 internal strobe generator: toggles its output at a half period set by the
 divider option while enabled. assumes enable comes from the same clock.
 the undivided option toggles every system clock.
*/
`timescale 1ns/1ns
module strobe_gen (
   input  wire logic                      clk_i,    // system clock
   input  wire logic                      reset_i,  // synchronous reset
   input  wire logic                      run_i,    // strobe active
   input  wire adc_link_pkg::strobe_div_t div_i,    // divider option
   output logic                           tick_o,   // toggle this cycle
   output logic                           level_o   // strobe level
);
   import adc_link_pkg::*;

   typedef struct packed {
      logic [1:0] cnt;
      logic       level;
   } sg_state_t;

   sg_state_t state_reg;
   sg_state_t state_next;
   logic [1:0] half;

   // equal high and low phases keep the duty cycle at one half
   always_comb begin
      case (div_i)
         DIV_1:   half = 2'h0;
         DIV_2:   half = DIV2_HALF;
         DIV_4:   half = DIV4_HALF;
         default: half = 2'h0;
      endcase
      state_next = state_reg;
      tick_o     = 1'b0;
      if (!run_i) begin
         // preload so the first enabled cycle toggles whatever the divider
         state_next       = '0;
         state_next.cnt   = half;
      end else if (state_reg.cnt >= half) begin
         state_next.cnt   = 2'h0;
         state_next.level = ~state_reg.level;
         tick_o           = 1'b1;
      end else begin
         state_next.cnt = state_reg.cnt + 2'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign level_o = state_reg.level;
endmodule

//--- bench/adc_serial_link_timing_monitor.sv
/*
 checker for the serial link timing block, watching its ports only.
 assumes the 50 MHz clock; attached by bind.
*/
`timescale 1ns/1ns
module adc_serial_link_timing_monitor #(
   parameter int unsigned DATA_W      = 16,
   parameter int unsigned READY_CYC   = adc_link_pkg::RESET_READY_CYC,
   parameter int unsigned PWRUP_CYC_P = adc_link_pkg::PWRUP_CYC
) (
   input wire logic                     clk_i,                 // system clock
   input wire logic                     reset_i,               // synchronous reset
   input wire adc_link_pkg::link_pins_t pins_i,                // pins
   input wire adc_link_pkg::link_ctrl_t ctrl_i,                // controls
   input wire logic [DATA_W-1:0]        data_i,                // word
   input wire logic                     ready_strobe_output_o, // ready/strobe
   input wire logic                     sdo_o,                 // data out
   input wire logic                     sdo_oe_o,              // data enable
   input wire logic                     ready_o                // operational
);
   import adc_link_pkg::*;
   localparam int unsigned LOW_MAX = (READY_CYC > PWRUP_CYC_P ? READY_CYC : PWRUP_CYC_P) + 8;
   logic [16:0] low_cnt_reg;
   logic        src;
   logic        rso;
   assign src = ctrl_i.mode != MODE_SPI;
   assign rso = ready_strobe_output_o;
   // cycles spent not ready with nothing holding the device down
   always_ff @(posedge clk_i) begin
      if (reset_i || ready_o || ctrl_i.nap || ctrl_i.power_down || !pins_i.reset_n) begin
         low_cnt_reg <= '0;
      end else begin
         low_cnt_reg <= low_cnt_reg + 17'h1;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   chk_boot_hold: assert property (!reset_i && $past(reset_i) |-> !ready_o [*8])
      else $error("ready rose early after reset");
   chk_low_bound: assert property (low_cnt_reg <= LOW_MAX)
      else $error("recovery took too long");
   chk_nap_wake: assert property ($fell(ctrl_i.nap) && !ctrl_i.power_down |-> ##[1:20] ready_o)
      else $error("light sleep wake late");
   chk_strobe_fall: assert property ($fell(pins_i.cs_n) && ready_o && rso |-> ##[1:4] !rso)
      else $error("strobe did not fall at frame start");
   chk_nop_back: assert property ($rose(pins_i.cs_n) && sdo_oe_o && ctrl_i.kind != FRAME_RW
      |-> ##[1:4] rso)
      else $error("strobe late after frame");
   chk_rw_back: assert property ($rose(pins_i.cs_n) && sdo_oe_o && ctrl_i.kind == FRAME_RW && !src
      |-> !rso [*4] ##[1:6] rso)
      else $error("strobe return wrong after rw frame");
   chk_oe_off: assert property (pins_i.cs_n [*4] |=> !sdo_oe_o)
      else $error("data driven while deselected");
   chk_ext_step: assert property (ctrl_i.mode == MODE_SRC_EXT && sdo_oe_o && $rose(pins_i.sclk)
      |-> ##[3:5] $changed(rso))
      else $error("strobe missed a clock edge");
   chk_src_edge: assert property (src && sdo_oe_o && $past(sdo_oe_o) && $changed(sdo_o)
      |-> $changed(rso))
      else $error("data changed apart from strobe");
   chk_int_start: assert property (ctrl_i.mode == MODE_SRC_INT && ready_o && rso && $fell(pins_i.cs_n)
      |-> ##[4:6] $rose(rso))
      else $error("internal strobe start wrong");
   chk_int_div4: assert property (ctrl_i.mode == MODE_SRC_INT && ctrl_i.div == DIV_4 && sdo_oe_o
      && $past(sdo_oe_o, 2) && !pins_i.cs_n && $changed(rso) |=> $stable(rso))
      else $error("divided strobe phase too short");
endmodule
bind adc_serial_link_timing adc_serial_link_timing_monitor #(.DATA_W(DATA_W), .READY_CYC(READY_CYC),
   .PWRUP_CYC_P(PWRUP_CYC_P)) u_mon (.clk_i, .reset_i, .pins_i, .ctrl_i, .data_i,
   .ready_strobe_output_o, .sdo_o, .sdo_oe_o, .ready_o);

//--- bench/link_host_model.sv
/*
 host model: drives chip select, serial clock and reset pins.
 assumes the bench calls its tasks; serial clock stands low outside frames.
*/
`timescale 1ns/1ns
module link_host_model (
   input  wire logic                clk_i,  // system clock
   output adc_link_pkg::link_pins_t pins_o  // pins to the device
);
   import adc_link_pkg::*;
   initial pins_o = '{cs_n: 1'b1, sclk: 1'b0, reset_n: 1'b1};
   task automatic reset_pulse(input int n);
      @(posedge clk_i) #2 pins_o.reset_n = 1'b0;
      repeat (n) @(posedge clk_i);
      #2 pins_o.reset_n = 1'b1;
   endtask
   // hp system clocks per half period, far slower than the serial limits
   task automatic frame(input int nclk, input int hp, input int len);
      @(posedge clk_i) #2 pins_o.cs_n = 1'b0;
      repeat (4) @(posedge clk_i);
      for (int i = 0; i < 2 * nclk; i++) begin
         #2 pins_o.sclk = ~pins_o.sclk;
         repeat (hp) @(posedge clk_i);
      end
      repeat (len) @(posedge clk_i);
      #2 pins_o.cs_n = 1'b1;
   endtask
endmodule

//--- bench/adc_serial_link_timing_test.sv
/*
 self-checking bench: reset and sleep recovery, frames in every mode and
 divider option, frames refused while asleep. assumes the host model.
*/
`timescale 1ns/1ns
module adc_serial_link_timing_test;
   import adc_link_pkg::*;
   localparam int RDY = 20;
   localparam int PWR = 30;
   logic        clk_i = 1'b0;
   logic        reset_i = 1'b1;
   link_pins_t  pins;
   link_ctrl_t  ctrl;
   logic [15:0] data;
   logic        rso, sdo, oe, rdy;
   logic        oe_d = 1'b0;
   logic        rso_d = 1'b0;
   logic [31:0] seed = 32'h06f47c97;
   logic        bits[$];
   int          gaps[$];
   int          cyc = 0;
   int          last_t = 0;
   int          n_errors = 0;
   int          check_count = 0;
   always #10 clk_i = ~clk_i;
   link_host_model u_host (.clk_i(clk_i), .pins_o(pins));
   adc_serial_link_timing #(.READY_CYC(RDY), .PWRUP_CYC_P(PWR)) u_adc_serial_link_timing (
      .clk_i(clk_i), .reset_i(reset_i), .pins_i(pins), .ctrl_i(ctrl), .data_i(data),
      .ready_strobe_output_o(rso), .sdo_o(sdo), .sdo_oe_o(oe), .ready_o(rdy));
   // reference: each new bit is taken at enable rise and, outside spi mode, at every strobe edge
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      oe_d <= oe;
      rso_d <= rso;
      if (oe === 1'b1 && (!oe_d || (ctrl.mode != MODE_SPI && rso !== rso_d))) begin
         bits.push_back(sdo);
         gaps.push_back(cyc - last_t);
         last_t <= cyc;
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic summarize();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic wait_rso(input int lim, output int n);
      n = 0;
      while (rso !== 1'b1 && n < lim) begin
         @(posedge clk_i) #2;
         n++;
      end
      if (n >= lim) begin
         n_errors++;
         summarize();
      end
   endtask
   task automatic run_frame(input int m, input int d);
      int half;
      ctrl.mode = link_mode_t'(m);
      ctrl.div = strobe_div_t'(d);
      ctrl.kind = frame_kind_t'(rnd() % 3);
      data = 16'(rnd());
      half = 1 << d;
      bits.delete();
      gaps.delete();
      u_host.frame(m == 2 ? 0 : 15 + d, 3 + 2 * d, m == 2 ? 10 + 20 * d : 6);
      repeat (8) @(posedge clk_i);
      #2;
      check(oe, 1'b0);
      check(rso, 1'b1);
      if (m == 1) check(bits.size(), 16 + d);
      for (int i = 0; i < bits.size(); i++) check(bits[i], i < 16 ? data[15 - i] : 1'b0);
      for (int i = 2; m == 2 && i < gaps.size(); i++) check(gaps[i], half);
   endtask
   initial begin
      int n;
      ctrl = '0;
      data = '0;
      repeat (10) @(posedge clk_i);
      #2 reset_i = 1'b0;
      check(rdy, 1'b0);
      wait_rso(RDY + 10, n);
      check(n >= RDY - 2 && n <= RDY + 3, 1'b1);
      u_host.reset_pulse(6);
      wait_rso(RDY + 10, n);
      check(n >= RDY - 2 && n <= RDY + 3, 1'b1);
      for (int m = 0; m < 3; m++) begin
         for (int d = 0; d < 3; d++) begin
            run_frame(m, d);
         end
      end
      for (int s = 0; s < 2; s++) begin
         ctrl.nap = (s == 0);
         ctrl.power_down = (s == 1);
         repeat (4) @(posedge clk_i);
         #2;
         check(rdy, 1'b0);
         bits.delete();
         u_host.frame(4, 3, 4);
         check(bits.size(), 0);
         ctrl.nap = 1'b0;
         ctrl.power_down = 1'b0;
         wait_rso(PWR + 10, n);
         check(n <= (s == 1 ? PWR : NAP_WAKE_CYC) + 4, 1'b1);
         check(n >= (s == 1 ? PWR - 4 : 0), 1'b1);
      end
      summarize();
   end
endmodule
